// ### rcdcw_pkg.sv
package rcdcw_pkg;

    localparam int unsigned NUM_WORDS = 16;
    localparam int unsigned WORD_W = 4;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned BANK_W = 3;

    // control word index of the global features word
    localparam logic [3:0] GLOBAL_FEATURES_IDX = 4'h0;
    // global features bit: 1 turns output inversion off
    localparam int unsigned INV_DISABLE_BIT = 0;

    // address bits that must be low for a valid word write
    localparam int unsigned ADDR_ZERO_LSB = 5;

    // B-side bits complemented while inversion is active
    localparam logic [15:0] INV_ADDR_MASK = 16'hEBF8;
    localparam logic [2:0] INV_BANK_MASK = 3'h7;

    // reset values
    localparam logic [3:0] WORD_RST = 4'h0;
    localparam logic [3:0] CS_IDLE = 4'hF;
    localparam logic [1:0] CKE_RST = 2'h0;
    localparam logic [1:0] ODT_RST = 2'h0;
    localparam logic [1:0] CNT_ZERO = 2'h0;

    // clock at 10 MHz; mode-set timing is given in clocks
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam logic [1:0] MRS_GAP_CLK = 2'h3;
    // 3T: value on outputs for three clocks, i.e. two held clocks
    localparam logic [1:0] MRS_HOLD_CLK = MRS_GAP_CLK - 2'h1;

endpackage : rcdcw_pkg

// ### rcdcw_top.sv
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module rcdcw_top
    import rcdcw_pkg::*;
#(
    // arbitrary defaults for the two vendor words
    parameter logic [3:0] VENDOR_WORD_A_RST = 4'h0,
    parameter logic [3:0] VENDOR_WORD_B_RST = 4'h0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic four_rank_select_mode_i,
    input wire logic [3:0] chip_select_in_n_i,
    input wire logic row_strobe_in_n_i,
    input wire logic col_strobe_in_n_i,
    input wire logic write_enable_in_n_i,
    input wire logic [15:0] addr_in_i,
    input wire logic [2:0] bank_in_i,
    input wire logic [1:0] termination_in_i,
    input wire logic [1:0] clock_enable_in_i,
    input wire logic parity_in_i,
    output logic [15:0] addr_a_o,
    output logic [15:0] addr_b_o,
    output logic [2:0] bank_a_o,
    output logic [2:0] bank_b_o,
    output logic row_strobe_out_n_o,
    output logic col_strobe_out_n_o,
    output logic write_enable_out_n_o,
    output logic [3:0] chip_select_out_n_o,
    output logic [1:0] clock_enable_out_o,
    output logic [1:0] termination_out_o,
    output logic parity_error_out_o,
    output logic parity_error_out_oe_o,
    output logic inversion_active_o,
    output logic [63:0] control_words_o
);

    //////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0][3:0] cw;
        logic [15:0] addr_a;
        logic [15:0] addr_b;
        logic [2:0] bank_a;
        logic [2:0] bank_b;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [3:0] cs_n;
        logic [1:0] cke;
        logic [1:0] odt;
        logic err;
        logic err_lvl;
        logic inv;
        logic [1:0] mrs_cnt;
        logic [1:0] hold_cnt;
        logic [3:0] cs_pend;
        logic cs_pend_v;
        logic cke_any;
    } rcdcw_state_s;

    rcdcw_state_s state_r;
    rcdcw_state_s state_nxt;

    //////////////////////////////////////////////////////////////////////////
    function automatic logic one_low(input logic [3:0] cs_n);
        logic [2:0] cnt;
        cnt = 3'h0;
        for (int i = 0; i < 4; i++) begin
            cnt = cnt + {2'h0, ~cs_n[i]};
        end
        return cnt == 3'h1;
    endfunction

    function automatic logic [3:0] dec_cnt(input logic [1:0] c);
        return {2'h0, (c == CNT_ZERO) ? CNT_ZERO : c - 2'h1};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    logic [3:0] cs_eff;
    logic cw_access;
    logic cw_valid;
    logic parity_bad;
    logic mrs_cmd;
    logic cke_any;
    logic pd_exit;
    logic [3:0] cw_idx;
    logic [3:0] cw_data;
    logic [3:0] dec_mrs;
    logic [3:0] dec_hold;

    always_comb begin
        // dual mode: upper chip selects read as idle
        cs_eff = four_rank_select_mode_i ? chip_select_in_n_i
                                         : {2'b11, chip_select_in_n_i[1:0]};
        // quad: upper pair low covers the all-four-low case too
        cw_access = four_rank_select_mode_i ?
            (chip_select_in_n_i[3:2] == 2'b00) :
            (chip_select_in_n_i[1:0] == 2'b00);
        cke_any = |clock_enable_in_i;
        cw_valid = (addr_in_i[15:ADDR_ZERO_LSB] == '0) && cke_any;
        parity_bad = ^{addr_in_i, bank_in_i, row_strobe_in_n_i,
                       col_strobe_in_n_i, write_enable_in_n_i,
                       parity_in_i};
        mrs_cmd = !row_strobe_in_n_i && !col_strobe_in_n_i &&
                  !write_enable_in_n_i && one_low(cs_eff) &&
                  !cw_access;
        pd_exit = cke_any && !state_r.cke_any;
        cw_idx = {bank_in_i[2], addr_in_i[2:0]};
        cw_data = {bank_in_i[1:0], addr_in_i[4:3]};
        dec_mrs = dec_cnt(state_r.mrs_cnt);
        dec_hold = dec_cnt(state_r.hold_cnt);
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        state_nxt.err = 1'b0;
        state_nxt.err_lvl = 1'b0;
        state_nxt.mrs_cnt = dec_mrs[1:0];
        state_nxt.hold_cnt = dec_hold[1:0];
        state_nxt.cke_any = cke_any;

        if (cw_access) begin
            // termination not looked at here; strobes count only in the parity check
            state_nxt.cs_n = CS_IDLE;
            // timing word and inversion state play no part
            if (cw_valid) begin
                if (parity_bad) begin
                    state_nxt.err = 1'b1;
                end else begin
                    state_nxt.cw[cw_idx] = cw_data;
                end
            end
        end else if (state_r.hold_cnt != CNT_ZERO) begin
            // address and command stay put
            state_nxt.cke = clock_enable_in_i;
            state_nxt.odt = termination_in_i;
            if (state_r.cs_pend_v) begin
                state_nxt.cs_n = state_r.cs_pend;
                state_nxt.cs_pend_v = 1'b0;
            end else begin
                state_nxt.cs_n = cs_eff;
            end
        end else begin
            state_nxt.addr_a = addr_in_i;
            state_nxt.bank_a = bank_in_i;
            state_nxt.ras_n = row_strobe_in_n_i;
            state_nxt.cas_n = col_strobe_in_n_i;
            state_nxt.we_n = write_enable_in_n_i;
            state_nxt.cke = clock_enable_in_i;
            state_nxt.odt = termination_in_i;
            if (mrs_cmd) begin
                // a closer mode-set is a host fault
                state_nxt.mrs_cnt = MRS_GAP_CLK;
                state_nxt.hold_cnt = MRS_HOLD_CLK;
                state_nxt.cs_pend = cs_eff;
                state_nxt.cs_pend_v = 1'b1;
                state_nxt.cs_n = CS_IDLE;
            end else if (pd_exit) begin
                state_nxt.cs_n = CS_IDLE;
            end else begin
                state_nxt.cs_n = cs_eff;
            end
        end

        state_nxt.err_lvl = 1'b0;
        // suspended while a mode-set window runs
        state_nxt.inv = !state_nxt.cw[GLOBAL_FEATURES_IDX][INV_DISABLE_BIT]
                        && (state_nxt.mrs_cnt == CNT_ZERO);
        // B copies A, complemented only under inversion
        state_nxt.addr_b = state_nxt.addr_a ^
                           (INV_ADDR_MASK & {ADDR_W{state_nxt.inv}});
        state_nxt.bank_b = state_nxt.bank_a ^
                           (INV_BANK_MASK & {BANK_W{state_nxt.inv}});
    end

    //////////////////////////////////////////////////////////////////////////
    // words persist while the clock stands still: no edge, no change
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                state_r.cw[i] <= WORD_RST;
            end
            state_r.cw[6] <= VENDOR_WORD_A_RST;
            state_r.cw[7] <= VENDOR_WORD_B_RST;
            state_r.addr_a <= '0;
            // B side already complemented: inversion is on out of reset
            state_r.addr_b <= INV_ADDR_MASK;
            state_r.bank_a <= '0;
            state_r.bank_b <= INV_BANK_MASK;
            state_r.ras_n <= 1'b1;
            state_r.cas_n <= 1'b1;
            state_r.we_n <= 1'b1;
            state_r.cs_n <= CS_IDLE;
            state_r.cke <= CKE_RST;
            state_r.odt <= ODT_RST;
            state_r.err <= 1'b0;
            state_r.err_lvl <= 1'b0;
            state_r.inv <= 1'b1;
            state_r.mrs_cnt <= CNT_ZERO;
            state_r.hold_cnt <= CNT_ZERO;
            state_r.cs_pend <= CS_IDLE;
            state_r.cs_pend_v <= 1'b0;
            state_r.cke_any <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign addr_a_o = state_r.addr_a;
    assign addr_b_o = state_r.addr_b;
    assign bank_a_o = state_r.bank_a;
    assign bank_b_o = state_r.bank_b;
    assign row_strobe_out_n_o = state_r.ras_n;
    assign col_strobe_out_n_o = state_r.cas_n;
    assign write_enable_out_n_o = state_r.we_n;
    assign chip_select_out_n_o = state_r.cs_n;
    assign clock_enable_out_o = state_r.cke;
    assign termination_out_o = state_r.odt;
    // open drain: only ever pulls low
    assign parity_error_out_o = state_r.err_lvl;
    assign parity_error_out_oe_o = state_r.err;
    assign inversion_active_o = state_r.inv;
    assign control_words_o = state_r.cw;

endmodule // rcdcw_top

`default_nettype wire

// ### rcdcw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rcdcw_asserts
    import rcdcw_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic four_rank_select_mode_i,
    input wire logic [3:0] chip_select_in_n_i,
    input wire logic row_strobe_in_n_i,
    input wire logic col_strobe_in_n_i,
    input wire logic write_enable_in_n_i,
    input wire logic [15:0] addr_in_i,
    input wire logic [2:0] bank_in_i,
    input wire logic [1:0] clock_enable_in_i,
    input wire logic parity_in_i,
    input wire logic [15:0] addr_a_o,
    input wire logic [15:0] addr_b_o,
    input wire logic [2:0] bank_a_o,
    input wire logic [2:0] bank_b_o,
    input wire logic [3:0] chip_select_out_n_o,
    input wire logic [1:0] clock_enable_out_o,
    input wire logic [1:0] termination_out_o,
    input wire logic parity_error_out_oe_o,
    input wire logic inversion_active_o,
    input wire logic [63:0] control_words_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic [3:0] low;
    logic cw, mrs, ok, pbad;
    logic [3:0] idx_q, dat_q;
    assign low = ~chip_select_in_n_i;
    // all four low also has both upper ones low
    assign cw = four_rank_select_mode_i ? &low[3:2] : &low[1:0];
    assign mrs = ~|{row_strobe_in_n_i, col_strobe_in_n_i,
        write_enable_in_n_i} && (four_rank_select_mode_i ?
        $onehot(low) : $onehot(low[1:0]));
    assign ok = cw && addr_in_i[15:5] == 11'h000 && |clock_enable_in_i;
    assign pbad = ^{addr_in_i, bank_in_i, row_strobe_in_n_i,
        col_strobe_in_n_i, write_enable_in_n_i, parity_in_i};
    always_ff @(posedge clk_i) begin
        idx_q <= {bank_in_i[2], addr_in_i[2:0]};
        dat_q <= {bank_in_i[1:0], addr_in_i[4:3]};
    end
    //////////////////////////////////////////////////////////////////////
    a_cw_write: assert property (
        ok && !pbad |=> control_words_o[idx_q*4 +: 4] == dat_q)
        else $error("word write lost");
    a_parity_drop: assert property (
        ok && pbad |=> parity_error_out_oe_o && $stable(control_words_o))
        else $error("parity write not dropped");
    a_cw_cs_high: assert property (cw |=> chip_select_out_n_o == CS_IDLE)
        else $error("cs out low in word access");
    a_cw_hold: assert property (cw |=> $stable(clock_enable_out_o) &&
        $stable(termination_out_o) && $stable(addr_a_o))
        else $error("outputs moved in word access");
    a_mrs_cs: assert property (mrs |=> chip_select_out_n_o == CS_IDLE &&
        !inversion_active_o ##1 chip_select_out_n_o == $past(chip_select_in_n_i, 2))
        else $error("mode set cs delay wrong");
    a_three_t: assert property (mrs |=> ##1 $stable(addr_a_o) [*2])
        else $error("3T hold broken");
    a_inv_back: assert property (
        mrs && !control_words_o[INV_DISABLE_BIT] ##3 !mrs |=> inversion_active_o)
        else $error("inversion not restored");
    a_ab_match: assert property ($past(resetn_i) |->
        addr_b_o == (addr_a_o ^ (inversion_active_o ? INV_ADDR_MASK : 16'h0000))
        && bank_b_o == (bank_a_o ^ (inversion_active_o ? INV_BANK_MASK : 3'h0)))
        else $error("B side wrong");
    a_pd_exit: assert property ($past(clock_enable_in_i) == 2'h0 &&
        clock_enable_in_i != 2'h0 |=> chip_select_out_n_o == CS_IDLE)
        else $error("cs out not held on exit");
    c_write: cover property (ok && !pbad);
    c_perr: cover property (parity_error_out_oe_o);
    c_mrs: cover property (mrs);
endmodule // rcdcw_asserts
bind rcdcw_top rcdcw_asserts rcdcw_asserts_i (.*);
`default_nettype wire

// ### rcdcw_host.sv
`timescale 1ns/1ps
`default_nettype none
module rcdcw_host (
    input wire logic clk_i,
    output logic [3:0] cs_n_o,
    output logic row_n_o,
    output logic col_n_o,
    output logic we_n_o,
    output logic [15:0] addr_o,
    output logic [2:0] bank_o,
    output logic [1:0] odt_o,
    output logic [1:0] cke_o,
    output logic par_o
);
    // cke low at start so leaving reset is also a power-down exit
    initial begin
        {cs_n_o, row_n_o, col_n_o, we_n_o, par_o} = 8'hFF;
        {addr_o, bank_o, odt_o, cke_o} = 23'h00_0000;
    end
    task automatic cyc(input logic [3:0] cs, input logic [2:0] cmd,
            input logic [15:0] a, input logic [2:0] b, input logic bad);
        @(negedge clk_i);
        cs_n_o = cs;
        {row_n_o, col_n_o, we_n_o} = cmd;
        addr_o = a;
        bank_o = b;
        odt_o = b[1:0];
        cke_o = 2'h3;
        par_o = ^{a, b, cmd} ^ bad;
    endtask
endmodule // rcdcw_host
`default_nettype wire

// ### rcdcw_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rcdcw_top_tb;
    logic clk_i = 1'b0, resetn_i = 1'b0, four_rank_select_mode_i = 1'b0;
    logic [3:0] chip_select_in_n_i, chip_select_out_n_o;
    logic row_strobe_in_n_i, col_strobe_in_n_i, write_enable_in_n_i;
    logic parity_in_i, row_strobe_out_n_o, col_strobe_out_n_o;
    logic write_enable_out_n_o, parity_error_out_o, parity_error_out_oe_o;
    logic inversion_active_o;
    logic [15:0] addr_in_i, addr_a_o, addr_b_o;
    logic [2:0] bank_in_i, bank_a_o, bank_b_o;
    logic [1:0] termination_in_i, clock_enable_in_i;
    logic [1:0] clock_enable_out_o, termination_out_o;
    logic [63:0] control_words_o, ew;
    int n_fail = 0, n_compared = 0;
    always #50 clk_i = ~clk_i;
    rcdcw_top rcdcw_top_i (.*);
    rcdcw_host rcdcw_host_i (
        .clk_i(clk_i),
        .cs_n_o(chip_select_in_n_i),
        .row_n_o(row_strobe_in_n_i),
        .col_n_o(col_strobe_in_n_i),
        .we_n_o(write_enable_in_n_i),
        .addr_o(addr_in_i),
        .bank_o(bank_in_i),
        .odt_o(termination_in_i),
        .cke_o(clock_enable_in_i),
        .par_o(parity_in_i)
    );
    //////////////////////////////////////////////////////////////////////
    task check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // all chip selects high between accesses
    task idle(input int n);
        repeat (n) rcdcw_host_i.cyc(4'hF, 3'h7, 16'h0000, 3'h0, 1'b0);
    endtask
    // strobes low on purpose: the access must ignore them
    task automatic cw(input logic [3:0] cs, i, d, input logic bad, junk);
        rcdcw_host_i.cyc(cs, 3'h0, {10'h000, junk, d[1:0], i[2:0]},
            {i[3], d[3:2]}, bad);
        idle(1);
        if (!bad && !junk) ew[i*4 +: 4] = d;
        check(control_words_o, ew);
        check(parity_error_out_oe_o, bad & ~junk);
        check(parity_error_out_o, 1'b0);
        check(chip_select_out_n_o, 4'hF);
        check(termination_out_o, 2'h0);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge clk_i);
        n_fail++;
        complete_run;
    end
    initial begin
        ew = 64'h0000_0000_0000_0000;
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        // first call raises clock enable: a power-down exit with cs low
        rcdcw_host_i.cyc(4'hE, 3'h7, 16'h0000, 3'h0, 1'b0);
        idle(1);
        check(chip_select_out_n_o, 4'hF);
        check(inversion_active_o, 1'h1);
        check(addr_b_o, 16'hEBF8);
        check(control_words_o, ew);
        rcdcw_host_i.cyc(4'hE, 3'h7, 16'h0000, 3'h0, 1'b0);
        idle(1);
        check(chip_select_out_n_o, 4'hE);
        for (int k = 0; k < 16; k++) begin
            cw(4'hC, k[3:0], k[3:0] ^ 4'hA, 1'b0, 1'b0);
        end
        cw(4'hC, 4'h3, 4'h5, 1'b1, 1'b0);
        cw(4'hC, 4'h4, 4'h1, 1'b0, 1'b1);
        @(negedge clk_i) four_rank_select_mode_i = 1'b1;
        cw(4'h3, 4'h9, 4'h6, 1'b0, 1'b0);
        cw(4'h0, 4'hF, 4'h9, 1'b0, 1'b0);
        rcdcw_host_i.cyc(4'hE, 3'h0, 16'h1234, 3'h5, 1'b0);
        idle(1);
        check(inversion_active_o, 1'h0);
        check(addr_b_o, 16'h1234);
        check(bank_b_o, 3'h5);
        check({row_strobe_out_n_o, col_strobe_out_n_o,
            write_enable_out_n_o}, 3'h0);
        check(chip_select_out_n_o, 4'hF);
        idle(1);
        check(chip_select_out_n_o, 4'hE);
        check(addr_a_o, 16'h1234);
        check({row_strobe_out_n_o, col_strobe_out_n_o,
            write_enable_out_n_o}, 3'h0);
        check(bank_a_o, 3'h5);
        cw(4'h3, 4'h2, 4'h7, 1'b0, 1'b0);
        check(inversion_active_o, 1'h1);
        complete_run;
    end
endmodule // rcdcw_top_tb
`default_nettype wire
